// *** dsp_ram_port.sv ***
// Purpose: AXI4-Lite register window giving indirect access to processor RAM.
// Assumes: Single clock; processor RAM answers each request with one ack pulse.
// Notes:   Only byte lane 0 carries register data; upper bits read as zero.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module dsp_ram_port
    import dsp_ram_port_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output      logic                  s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output      logic                  s_axi_wready,
    // AXI4-Lite write response
    output      logic [1:0]            s_axi_bresp,
    output      logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output      logic                  s_axi_arready,
    // AXI4-Lite read data
    output      logic [31:0]           s_axi_rdata,
    output      logic [1:0]            s_axi_rresp,
    output      logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Processor RAM port
    output      logic                  ram_req,
    output      logic                  ram_we,
    output      logic [RAM_ADDR_W-1:0] ram_addr,
    output      logic [RAM_DATA_W-1:0] ram_wdata,
    input  wire logic                  ram_ack,
    input  wire logic [RAM_DATA_W-1:0] ram_rdata,
    // Interrupt
    output      logic                  irq
);

    // ------------------------------------------------------------------
    // Bus write path
    // ------------------------------------------------------------------
    // Address and data are caught independently so either may come first.
    logic              aw_held_q, aw_held_d;
    logic [5:0]        aw_idx_q, aw_idx_d;
    logic              w_held_q, w_held_d;
    logic [7:0]        w_byte_q, w_byte_d;
    logic              w_lane0_q, w_lane0_d;
    logic              bvalid_q, bvalid_d;
    logic [1:0]        bresp_q, bresp_d;
    logic              wr_fire;
    logic              wr_hit;

    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready  = !w_held_q;
    assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;

    always_comb begin
        unique case (aw_idx_q)
            IDX_DATA_LOW, IDX_DATA_HIGH, IDX_ADDR_LOW, IDX_ADDR_CTRL,
            IDX_IRQ_STATUS, IDX_IRQ_MASK: wr_hit = 1'b1;
            default:                      wr_hit = 1'b0;
        endcase
    end

    always_comb begin
        aw_held_d = aw_held_q;
        aw_idx_d  = aw_idx_q;
        w_held_d  = w_held_q;
        w_byte_d  = w_byte_q;
        w_lane0_d = w_lane0_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            aw_idx_d  = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d  = 1'b1;
            w_byte_d  = s_axi_wdata[7:0];
            w_lane0_d = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_held_q <= 1'b0;
            aw_idx_q  <= '0;
            w_held_q  <= 1'b0;
            w_byte_q  <= '0;
            w_lane0_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            aw_idx_q  <= aw_idx_d;
            w_held_q  <= w_held_d;
            w_byte_q  <= w_byte_d;
            w_lane0_q <= w_lane0_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ------------------------------------------------------------------
    // Window registers and access control
    // ------------------------------------------------------------------
    ram_access_if acc ();

    logic [7:0]  data_low_q, data_low_d;
    logic [7:0]  data_high_q, data_high_d;
    logic [7:0]  addr_low_q, addr_low_d;
    logic [3:0]  addr_high_q, addr_high_d;
    logic        cont_read_q, cont_read_d;
    logic        write_sel_q, write_sel_d;
    logic        go_q, go_d;
    logic        issued_q, issued_d;
    logic        op_go_q, op_go_d;
    logic        op_we_q, op_we_d;
    logic [7:0]  status_q, status_d;
    logic [7:0]  mask_q, mask_d;
    logic        wr_en;
    logic        start;

    assign wr_en = wr_fire && w_lane0_q;
    // A host-started access is served ahead of the next continuous read.
    assign start = !issued_q && !acc.busy && (go_q || cont_read_q);

    always_comb begin
        data_low_d  = data_low_q;
        data_high_d = data_high_q;
        addr_low_d  = addr_low_q;
        addr_high_d = addr_high_q;
        cont_read_d = cont_read_q;
        write_sel_d = write_sel_q;
        go_d        = go_q;
        issued_d    = issued_q;
        op_go_d     = op_go_q;
        op_we_d     = op_we_q;
        status_d    = status_q;
        mask_d      = mask_q;
        if (wr_en) begin
            unique case (aw_idx_q)
                IDX_DATA_LOW:   data_low_d  = w_byte_q;
                IDX_DATA_HIGH:  data_high_d = w_byte_q;
                IDX_ADDR_LOW:   addr_low_d  = w_byte_q;
                IDX_ADDR_CTRL: begin
                    addr_high_d = w_byte_q[ADDR_HIGH_LSB +: ADDR_HIGH_W];
                    cont_read_d = w_byte_q[CONT_READ_BIT];
                    write_sel_d = w_byte_q[WRITE_SEL_BIT];
                    // Once set, go stays set until its own access completes, whatever the host writes.
                    if (!go_q) begin
                        go_d = w_byte_q[ACCESS_GO_BIT];
                    end
                end
                IDX_IRQ_STATUS: status_d = status_q & ~(w_byte_q & STATUS_IMPL);
                IDX_IRQ_MASK:   mask_d   = w_byte_q & STATUS_IMPL;
                default:        mask_d   = mask_q;
            endcase
        end
        if (start) begin
            issued_d = 1'b1;
            op_go_d  = go_q;
            op_we_d  = go_q && write_sel_q;
        end
        // Completion is applied after the host write so the hardware event wins.
        if (acc.done) begin
            issued_d = 1'b0;
            if (op_go_q) begin
                go_d = 1'b0;
            end
            if (!op_we_q) begin
                data_low_d  = acc.rdata[7:0];
                data_high_d = acc.rdata[15:8];
            end
            status_d[NEW_STATUS_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_low_q  <= DATA_RESET;
            data_high_q <= DATA_RESET;
            addr_low_q  <= ADDR_LOW_RESET;
            addr_high_q <= ADDR_HIGH_RESET;
            cont_read_q <= 1'b0;
            write_sel_q <= 1'b0;
            go_q        <= 1'b0;
            issued_q    <= 1'b0;
            op_go_q     <= 1'b0;
            op_we_q     <= 1'b0;
            status_q    <= '0;
            mask_q      <= MASK_RESET;
        end else begin
            data_low_q  <= data_low_d;
            data_high_q <= data_high_d;
            addr_low_q  <= addr_low_d;
            addr_high_q <= addr_high_d;
            cont_read_q <= cont_read_d;
            write_sel_q <= write_sel_d;
            go_q        <= go_d;
            issued_q    <= issued_d;
            op_go_q     <= op_go_d;
            op_we_q     <= op_we_d;
            status_q    <= status_d;
            mask_q      <= mask_d;
        end
    end

    // The engine latches address and data at start, so later host writes
    // cannot tear an access that is already on the RAM port.
    assign acc.start = start;
    assign acc.we    = go_q && write_sel_q;
    assign acc.addr  = {addr_high_q, addr_low_q};
    assign acc.wdata = {data_high_q, data_low_q};

    ram_access_engine u_engine (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .acc       (acc.engine),
        .ram_req   (ram_req),
        .ram_we    (ram_we),
        .ram_addr  (ram_addr),
        .ram_wdata (ram_wdata),
        .ram_ack   (ram_ack),
        .ram_rdata (ram_rdata)
    );

    assign irq = |(status_q & mask_q);

    // ------------------------------------------------------------------
    // Bus read path
    // ------------------------------------------------------------------
    logic        rvalid_q, rvalid_d;
    logic [7:0]  rbyte_q, rbyte_d;
    logic [1:0]  rresp_q, rresp_d;
    logic [7:0]  rd_byte;
    logic        rd_hit;

    assign s_axi_arready = !rvalid_q;

    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (s_axi_araddr[7:2])
            IDX_DATA_LOW:   rd_byte = data_low_q;
            IDX_DATA_HIGH:  rd_byte = data_high_q;
            IDX_ADDR_LOW:   rd_byte = addr_low_q;
            IDX_ADDR_CTRL:  rd_byte = {go_q, 1'b0, write_sel_q, cont_read_q, addr_high_q};
            IDX_IRQ_STATUS: rd_byte = status_q;
            IDX_IRQ_MASK:   rd_byte = mask_q;
            default:        rd_hit  = 1'b0;
        endcase
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rbyte_d  = rbyte_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rbyte_d  = rd_byte;
            rresp_d  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rvalid_q <= 1'b0;
            rbyte_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rbyte_q  <= rbyte_d;
            rresp_q  <= rresp_d;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = {24'h00_0000, rbyte_q};
    assign s_axi_rresp  = rresp_q;

endmodule

// *** dsp_ram_port_pkg.sv ***
// Purpose: Shared constants for the indirect processor RAM access port.
// Assumes: Byte address of each register is four times its index.
// Notes:   Register indices keep the interface location numbers.
package dsp_ram_port_pkg;

    // ------------------------------------------------------------------
    // Register indices and bus address width
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W          = 8;
    localparam logic [5:0]  IDX_DATA_LOW    = 6'h18;
    localparam logic [5:0]  IDX_DATA_HIGH   = 6'h19;
    localparam logic [5:0]  IDX_ADDR_LOW    = 6'h1C;
    localparam logic [5:0]  IDX_ADDR_CTRL   = 6'h1D;
    localparam logic [5:0]  IDX_IRQ_STATUS  = 6'h1F;
    localparam logic [5:0]  IDX_IRQ_MASK    = 6'h20;

    // ------------------------------------------------------------------
    // Field positions in the address/control register
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_HIGH_LSB   = 0;
    localparam int unsigned ADDR_HIGH_W     = 4;
    localparam int unsigned CONT_READ_BIT   = 4;
    localparam int unsigned WRITE_SEL_BIT   = 5;
    localparam int unsigned ACCESS_GO_BIT   = 7;

    // ------------------------------------------------------------------
    // Status register layout, mask register has the same layout
    // ------------------------------------------------------------------
    localparam int unsigned NEW_STATUS_BIT  = 3;
    localparam logic [7:0]  STATUS_IMPL     = 8'h08;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int unsigned RAM_ADDR_W      = 12;
    localparam int unsigned RAM_DATA_W      = 16;
    localparam logic [7:0]  DATA_RESET      = 8'h00;
    localparam logic [7:0]  ADDR_LOW_RESET  = 8'h00;
    localparam logic [3:0]  ADDR_HIGH_RESET = 4'h0;
    localparam logic [7:0]  MASK_RESET      = 8'h08;

    // ------------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

    typedef enum logic [0:0] {
        ENG_IDLE = 1'b0,
        ENG_WAIT = 1'b1
    } engine_state_e;

endpackage

// *** ram_access_if.sv ***
// Purpose: Request/answer bundle between the register block and the RAM engine.
// Assumes: One access in flight at a time.
// Notes:   start is a one-cycle pulse, done a one-cycle pulse.
`timescale 1ns/1ps
interface ram_access_if;
    import dsp_ram_port_pkg::*;
    logic                  start;
    logic                  we;
    logic [RAM_ADDR_W-1:0] addr;
    logic [RAM_DATA_W-1:0] wdata;
    logic                  busy;
    logic                  done;
    logic [RAM_DATA_W-1:0] rdata;

    modport requester (output start, we, addr, wdata, input busy, done, rdata);
    modport engine    (input start, we, addr, wdata, output busy, done, rdata);
endinterface

// *** ram_access_engine.sv ***
// Purpose: Runs one read or write against the processor RAM port.
// Assumes: The RAM raises ram_ack for one cycle with read data valid alongside.
// Notes:   Request and payload are held steady until acknowledged.
`timescale 1ns/1ps
module ram_access_engine
    import dsp_ram_port_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Request side
    ram_access_if.engine               acc,
    // Processor RAM port
    output      logic                  ram_req,
    output      logic                  ram_we,
    output      logic [RAM_ADDR_W-1:0] ram_addr,
    output      logic [RAM_DATA_W-1:0] ram_wdata,
    input  wire logic                  ram_ack,
    input  wire logic [RAM_DATA_W-1:0] ram_rdata
);

    engine_state_e         state_q, state_d;
    logic                  we_q, we_d;
    logic [RAM_ADDR_W-1:0] addr_q, addr_d;
    logic [RAM_DATA_W-1:0] wdata_q, wdata_d;
    logic [RAM_DATA_W-1:0] rdata_q, rdata_d;
    logic                  done_q, done_d;

    always_comb begin
        state_d = state_q;
        we_d    = we_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        done_d  = 1'b0;
        case (state_q)
            ENG_IDLE: begin
                if (acc.start) begin
                    state_d = ENG_WAIT;
                    we_d    = acc.we;
                    addr_d  = acc.addr;
                    wdata_d = acc.wdata;
                end
            end
            ENG_WAIT: begin
                if (ram_ack) begin
                    state_d = ENG_IDLE;
                    done_d  = 1'b1;
                    if (!we_q) begin
                        rdata_d = ram_rdata;
                    end
                end
            end
            default: state_d = ENG_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ENG_IDLE;
            we_q    <= 1'b0;
            addr_q  <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            we_q    <= we_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            done_q  <= done_d;
        end
    end

    assign ram_req   = (state_q == ENG_WAIT);
    assign ram_we    = we_q;
    assign ram_addr  = addr_q;
    assign ram_wdata = wdata_q;
    assign acc.busy  = (state_q != ENG_IDLE);
    assign acc.done  = done_q;
    assign acc.rdata = rdata_q;

endmodule

// *** dsp_ram_port_props.sv ***
// Purpose: Port-level checks for the indirect RAM access port.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Bound to the top module from the bench file.
`timescale 1ns/1ps
module dsp_ram_port_props
    import dsp_ram_port_pkg::*;
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  sys_rst,
    // Register bus
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    // RAM side and interrupt
    input wire logic                  ram_req,
    input wire logic                  ram_we,
    input wire logic [RAM_ADDR_W-1:0] ram_addr,
    input wire logic [RAM_DATA_W-1:0] ram_wdata,
    input wire logic                  ram_ack,
    input wire logic                  irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_req_hold;
        ram_req && !ram_ack |=> ram_req && $stable({ram_we, ram_addr, ram_wdata});
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("ram request moved");
    property p_req_end;
        ram_req && ram_ack |=> !ram_req;
    endproperty
    a_req_end: assert property (p_req_end) else $error("ram request outlived ack");
    property p_irq_cause;
        $rose(irq) |-> $past(ram_ack, 2) || $past(s_axi_wvalid, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write response late");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer wrong");
    property p_b_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_once: assert property (p_b_once) else $error("write response repeated");
    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_r_once: assert property (p_r_once) else $error("read response repeated");
    property p_reset_vals;
        $fell(sys_rst) |-> !ram_req && !irq && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("not idle after reset");
endmodule

// *** dsp_ram_model.sv ***
// Purpose: Behavioural processor RAM behind the access port.
// Assumes: One request at a time; ack comes lat+1 cycles after the request.
// Notes:   Read bus toggles outside the ack cycle so stale data never matches.
`timescale 1ns/1ps
module dsp_ram_model
    import dsp_ram_port_pkg::*;
(
    // Clock and latency
    input  wire logic                  clk,
    input  wire logic [3:0]            lat,
    // Request
    input  wire logic                  ram_req,
    input  wire logic                  ram_we,
    input  wire logic [RAM_ADDR_W-1:0] ram_addr,
    input  wire logic [RAM_DATA_W-1:0] ram_wdata,
    // Answer
    output      logic                  ram_ack,
    output      logic [RAM_DATA_W-1:0] ram_rdata
);
    logic [RAM_DATA_W-1:0] mem [2**RAM_ADDR_W];
    logic [3:0]            cnt_q;
    initial begin
        ram_ack   = 1'b0;
        ram_rdata = 16'h0000;
        cnt_q     = 4'h0;
    end
    always @(posedge clk) begin
        ram_ack   <= 1'b0;
        ram_rdata <= ~ram_rdata;
        if (!ram_req || ram_ack) begin
            cnt_q <= 4'h0;
        end else if (cnt_q == lat) begin
            ram_ack   <= 1'b1;
            ram_rdata <= mem[ram_addr];
            if (ram_we) mem[ram_addr] <= ram_wdata;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// *** tb_indirect_dsp_ram_access_port.sv ***
// Purpose: Self-checking bench for the indirect RAM access port.
// Assumes: Register byte address is four times the index.
// Notes:   Table rows cover plain register access; hand tests follow.
`timescale 1ns/1ps
module tb_indirect_dsp_ram_access_port import dsp_ram_port_pkg::*;;
    typedef struct packed {
        logic [5:0] idx;
        logic [7:0] rv;
        logic [7:0] wd;
        logic [7:0] rb;
        logic [1:0] rs;
    } row_s;
    row_s rows [7] = '{'{IDX_DATA_LOW, 8'h00, 8'ha5, 8'ha5, RESP_OKAY},
        '{IDX_DATA_HIGH, 8'h00, 8'h3c, 8'h3c, RESP_OKAY},
        '{IDX_ADDR_LOW, 8'h00, 8'hff, 8'hff, RESP_OKAY},
        '{IDX_ADDR_CTRL, 8'h00, 8'h4f, 8'h0f, RESP_OKAY},
        '{IDX_IRQ_STATUS, 8'h00, 8'h00, 8'h00, RESP_OKAY},
        '{IDX_IRQ_MASK, 8'h08, 8'hff, 8'h08, RESP_OKAY},
        '{6'h3f, 8'h00, 8'h12, 8'h00, RESP_SLVERR}};
    logic                  clk = 1'b0, sys_rst = 1'b1;
    logic [ADDR_W-1:0]     s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]           s_axi_wdata = '0, s_axi_rdata;
    logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic                  s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic                  s_axi_rvalid, ram_req, ram_we, ram_ack, irq;
    logic [1:0]            s_axi_bresp, s_axi_rresp;
    logic [RAM_ADDR_W-1:0] ram_addr;
    logic [RAM_DATA_W-1:0] ram_wdata, ram_rdata;
    logic [3:0]            lat = 4'h0, s_axi_wstrb = 4'hf;
    int                    n_fail = 0, compares = 0;

    dsp_ram_port i_dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_ack, .ram_rdata, .irq);
    dsp_ram_model i_ram (.clk, .lat, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_ack,
        .ram_rdata);

    always #5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic tmo;
        n_fail++;
        print_verdict();
    endtask
    // Handshakes are sampled at the falling edge, where every ready is settled.
    task automatic axw(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic a, w, b;
        logic [1:0] r;
        @(posedge clk);
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            @(negedge clk);
            a = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) begin
                s_axi_bready <= 1'b0;
                chk({30'h0, r}, {30'h0, er});
                return;
            end
        end
        tmo();
    endtask
    task automatic axr(input logic [5:0] idx, output logic [7:0] d, output logic [1:0] r);
        logic a, v;
        @(posedge clk);
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            @(negedge clk);
            a = s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata[7:0];
            r = s_axi_rresp;
            @(posedge clk);
            if (a) s_axi_arvalid <= 1'b0;
            if (v) begin
                s_axi_rready <= 1'b0;
                return;
            end
        end
        tmo();
    endtask
    task automatic rdc(input logic [5:0] idx, input logic [7:0] e, input logic [1:0] er);
        logic [7:0] d;
        logic [1:0] r;
        axr(idx, d, r);
        chk({24'h0, d}, {24'h0, e});
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic poll(input logic [5:0] idx, input logic [7:0] m, input logic [7:0] want);
        logic [7:0] d;
        logic [1:0] r;
        for (int k = 0; k < 60; k++) begin
            axr(idx, d, r);
            if ((d & m) === want) return;
        end
        tmo();
    endtask
    task automatic irqc(input logic want);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, want});
    endtask

    initial begin
        repeat (50000) @(posedge clk);
        tmo();
    end

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            rdc(rows[i].idx, rows[i].rv, rows[i].rs);
            axw(rows[i].idx, rows[i].wd, rows[i].rs);
            rdc(rows[i].idx, rows[i].rb, rows[i].rs);
        end
        // Write through a slow RAM; address and data stay put until go clears.
        lat <= 4'h3;
        axw(IDX_ADDR_LOW, 8'h34, RESP_OKAY);
        axw(IDX_DATA_LOW, 8'hef, RESP_OKAY);
        axw(IDX_DATA_HIGH, 8'hbe, RESP_OKAY);
        axw(IDX_ADDR_CTRL, 8'haa, RESP_OKAY);
        poll(IDX_ADDR_CTRL, 8'h80, 8'h00);
        chk({16'h0, i_ram.mem[12'ha34]}, 32'h0000_beef);
        irqc(1'b1);
        rdc(IDX_IRQ_STATUS, 8'h08, RESP_OKAY);
        axw(IDX_IRQ_STATUS, 8'h08, RESP_OKAY);
        irqc(1'b0);
        // Read through a prompt RAM with the interrupt masked.
        lat <= 4'h0;
        axw(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
        axw(IDX_DATA_LOW, 8'h11, RESP_OKAY);
        axw(IDX_DATA_HIGH, 8'h22, RESP_OKAY);
        axw(IDX_ADDR_CTRL, 8'h8a, RESP_OKAY);
        poll(IDX_ADDR_CTRL, 8'h80, 8'h00);
        rdc(IDX_DATA_LOW, 8'hef, RESP_OKAY);
        rdc(IDX_DATA_HIGH, 8'hbe, RESP_OKAY);
        irqc(1'b0);
        axw(IDX_IRQ_MASK, 8'h08, RESP_OKAY);
        irqc(1'b1);
        axw(IDX_IRQ_STATUS, 8'h08, RESP_OKAY);
        // Continuous read picks up a RAM change without the go bit.
        i_ram.mem[12'ha34] <= 16'h1234;
        axw(IDX_ADDR_CTRL, 8'h1a, RESP_OKAY);
        poll(IDX_IRQ_STATUS, 8'h08, 8'h08);
        rdc(IDX_DATA_LOW, 8'h34, RESP_OKAY);
        rdc(IDX_DATA_HIGH, 8'h12, RESP_OKAY);
        rdc(IDX_ADDR_CTRL, 8'h1a, RESP_OKAY);
        axw(IDX_ADDR_CTRL, 8'h0a, RESP_OKAY);
        // Reset in the middle of a slow access.
        lat <= 4'hf;
        axw(IDX_ADDR_CTRL, 8'haa, RESP_OKAY);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rdc(IDX_ADDR_CTRL, 8'h00, RESP_OKAY);
        // A write with byte lane 0 disabled must leave the register alone.
        s_axi_wstrb <= 4'h0;
        axw(IDX_DATA_LOW, 8'h77, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rdc(IDX_DATA_LOW, 8'h00, RESP_OKAY);
        rdc(IDX_ADDR_LOW, 8'h00, RESP_OKAY);
        irqc(1'b0);
        print_verdict();
    end
endmodule

bind dsp_ram_port dsp_ram_port_props i_props (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ram_req, .ram_we,
    .ram_addr, .ram_wdata, .ram_ack, .irq);
